// >>> core/asc_pkg.sv
// Purpose: Shared constants for the axis status, sync and commutation block.
// Assumes: Avalon-MM word addressing, 32-bit data, 20 MHz clock.
// Notes: Every offset, field position and timing count lives here, with the reset values of config, mode, sample max, velocity timer and IRQ mask.

package asc_pkg;

    // ------------------------------------------------------------------
    // Register word addresses
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_STATE = 4'h0;
    localparam logic [3:0] ADDR_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_MODE = 4'h2;
    localparam logic [3:0] ADDR_COMMAND = 4'h3;
    localparam logic [3:0] ADDR_SAMPLE_MAX = 4'h4;
    localparam logic [3:0] ADDR_SAMPLE_TIMER = 4'h5;
    localparam logic [3:0] ADDR_VEL_TIMER = 4'h6;
    localparam logic [3:0] ADDR_DRIVE_REQ = 4'h7;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;
    localparam logic [3:0] ADDR_PHASE_ADV = 4'ha;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ST_SIGN_REV = 0;
    localparam int ST_FOUR_PHASE = 1;
    localparam int ST_FULL_COUNT = 2;
    localparam int ST_ZERO = 3;
    localparam int ST_TRAP = 4;
    localparam int ST_INIT = 5;
    localparam int ST_STOP_N = 6;
    localparam int ST_LIMIT_N = 7;
    localparam int MODE_TRAP = 0;
    localparam int MODE_INIT = 1;
    localparam int MODE_UNIPOLAR = 2;
    localparam int CMD_SYNC = 0;
    localparam int CMD_CLEAR_HALT = 1;
    localparam int IRQ_STOP = 0;
    localparam int IRQ_LIMIT = 1;
    localparam int IRQ_TICK = 2;
    localparam int IRQ_W = 3;

    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic [3:0] CONFIG_RST = 4'h0;
    localparam logic [2:0] MODE_RST = 3'h2;
    localparam logic [15:0] SAMPLE_MAX_RST = 16'h00f9;
    localparam logic [7:0] VEL_TIMER_RST = 8'h00;
    localparam logic [7:0] VEL_TIMER_MAX = 8'hff;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_KHZ = 20000;
    localparam int SYNC_PULSE_NS = 100;
    localparam int SYNC_CYCLES = (SYNC_PULSE_NS * CLK_KHZ + 999999) / 1000000;

endpackage

// >>> core/asc_sample_timer.sv
// Purpose: Axis sample timer, a down counter that reloads once per period.
// Assumes: Realign comes from logic on the same clock.
// Notes: Tick pulses for one cycle as the count reloads from zero, unless a realign comes at that edge.

`timescale 1ns/1ps

module asc_sample_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic [W-1:0] max_val,
    input wire logic realign,
    // Status
    output logic [W-1:0] count,
    output logic tick
);

    logic [W-1:0] next_count;
    logic next_tick;

    // Count down to zero, then reload; a realign restarts the period.
    always_comb
    begin
        next_tick = 1'b0;
        if (realign || count == '0)
        begin
            next_count = max_val;
            next_tick = ~realign && count == '0;
        end
        else
        begin
            next_count = count - 1'b1;
        end
    end

    // Register the counter.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count <= '0;
            tick <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tick <= next_tick;
        end
    end

    // A zero count reloads the programmed maximum on the next edge.
    property p_reload;
        @(posedge clk) disable iff (rst)
        (count == '0 && !realign) |=> (count == $past(max_val) && tick);
    endproperty
    a_reload: assert property (p_reload) else $error("sample timer did not reload");

endmodule // asc_sample_timer

// >>> core/asc_phase_adv.sv
// Purpose: Commutation phase advance from shaft speed and velocity timer.
// Assumes: Speed is an unsigned magnitude from encoder logic on this clock.
// Notes: Advance is the scaled product, registered, one cycle of latency.

`timescale 1ns/1ps

module asc_phase_adv (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inputs
    input wire logic [7:0] speed,
    input wire logic [7:0] vel_timer,
    // Result
    output logic [7:0] advance
);

    logic [15:0] product;
    logic [7:0] next_advance;

    // Advance grows with speed in proportion to the timer setting.
    always_comb
    begin
        product = speed * vel_timer;
        next_advance = product[15:8];
    end

    // Register the advance.
    always_ff @(posedge clk)
    begin
        if (rst)
            advance <= 8'h00;
        else
            advance <= next_advance;
    end

    // The output follows the scaled product one cycle later.
    property p_advance;
        @(posedge clk) disable iff (rst)
        ##1 advance == 8'(({8'h00, $past(speed)} * {8'h00, $past(vel_timer)}) >> 8);
    endproperty
    a_advance: assert property (p_advance) else $error("phase advance wrong");

endmodule // asc_phase_adv

// >>> core/asc_axis.sv
// Purpose: One axis: status word, board sync strobe, unipolar drive, velocity timer.
// Assumes: Avalon-MM slave with waitrequest; stop, limit and sync pins are asynchronous.
// Notes: Each access takes two cycles; reads of the status word have no effect.
//
// Register access over Avalon-MM and the address map were chosen for this implementation.

`timescale 1ns/1ps

module asc_axis (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Interrupt
    output logic irq,
    // Pins
    input wire logic stop_in,
    input wire logic limit_in,
    input wire logic sync_in_n,
    output logic sync_out_n,
    // Drive side
    input wire logic [7:0] shaft_speed,
    output logic [15:0] motor_cmd,
    output logic [7:0] phase_advance
);

    // ------------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SYNC_IDLE = 2'b01,
        SYNC_STROBE = 2'b10
    } asc_sync_t;

    localparam logic [3:0] SYNC_LEN = 4'(asc_pkg::SYNC_CYCLES);

    asc_sync_t sync_state, next_sync_state;
    logic [3:0] sync_cnt, next_sync_cnt;
    logic next_sync_out_n;
    logic ack, next_ack;
    logic [31:0] next_readdata;
    logic [3:0] cfg, next_cfg;
    logic [2:0] mode, next_mode;
    logic [15:0] sample_max, next_sample_max;
    logic [7:0] vel_timer, next_vel_timer;
    logic [15:0] drive_req, next_drive_req;
    logic [15:0] next_motor_cmd;
    logic stop_hit, next_stop_hit;
    logic limit_hit, next_limit_hit;
    logic [asc_pkg::IRQ_W-1:0] irq_status, next_irq_status;
    logic [asc_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;
    logic [2:0] pin_raw, pin_s1, pin_s2;
    logic sync_prev;
    logic [7:0] state_word;
    logic wr_en, rd_en, clear_cmd, sync_cmd, realign;
    logic [15:0] timer_count;
    logic timer_tick;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    assign pin_raw = {sync_in_n, limit_in, stop_in};

    // Two flip-flops per pin before any logic reads it.
    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    pin_s1[i] <= 1'(i == 2); // Idle levels: sync high, halts low.
                    pin_s2[i] <= 1'(i == 2);
                end
                else
                begin
                    pin_s1[i] <= pin_raw[i];
                    pin_s2[i] <= pin_s1[i];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    // Falling strobe realigns only while the axis is initializing.
    assign realign = sync_prev && !pin_s2[2] && mode[asc_pkg::MODE_INIT];
    asc_sample_timer #(.W(16)) u_timer (
        .clk(clk),
        .rst(rst),
        .max_val(sample_max),
        .realign(realign),
        .count(timer_count),
        .tick(timer_tick)
    );
    asc_phase_adv u_adv (
        .clk(clk),
        .rst(rst),
        .speed(shaft_speed),
        .vel_timer(vel_timer),
        .advance(phase_advance)
    );

    // ------------------------------------------------------------------
    // Status word and bus decode
    // ------------------------------------------------------------------
    // Status bits assembled live from the axis state.
    always_comb
    begin
        state_word = 8'h00;
        state_word[asc_pkg::ST_SIGN_REV] = cfg[asc_pkg::ST_SIGN_REV];
        state_word[asc_pkg::ST_FOUR_PHASE] = cfg[asc_pkg::ST_FOUR_PHASE];
        state_word[asc_pkg::ST_FULL_COUNT] = cfg[asc_pkg::ST_FULL_COUNT];
        state_word[asc_pkg::ST_ZERO] = 1'b0;
        state_word[asc_pkg::ST_TRAP] = mode[asc_pkg::MODE_TRAP];
        state_word[asc_pkg::ST_INIT] = mode[asc_pkg::MODE_INIT];
        state_word[asc_pkg::ST_STOP_N] = ~stop_hit;
        state_word[asc_pkg::ST_LIMIT_N] = ~limit_hit;
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign wr_en = avs_write && ack && avs_byteenable[0];
    assign rd_en = avs_read && ack;
    assign clear_cmd = wr_en && avs_address == asc_pkg::ADDR_COMMAND
        && avs_writedata[asc_pkg::CMD_CLEAR_HALT];
    assign sync_cmd = wr_en && avs_address == asc_pkg::ADDR_COMMAND
        && avs_writedata[asc_pkg::CMD_SYNC];
    assign irq = |(irq_status & irq_mask);

    // Read data is captured in the first cycle and presented in the second.
    always_comb
    begin
        case (avs_address)
            asc_pkg::ADDR_STATE: next_readdata = {24'h000000, state_word};
            asc_pkg::ADDR_CONFIG: next_readdata = {28'h0000000, 1'b0, cfg[2:0]};
            asc_pkg::ADDR_MODE: next_readdata = {29'h00000000, mode};
            asc_pkg::ADDR_SAMPLE_MAX: next_readdata = {16'h0000, sample_max};
            asc_pkg::ADDR_SAMPLE_TIMER: next_readdata = {16'h0000, timer_count};
            asc_pkg::ADDR_VEL_TIMER: next_readdata = {24'h000000, vel_timer};
            asc_pkg::ADDR_DRIVE_REQ: next_readdata = {16'h0000, drive_req};
            asc_pkg::ADDR_IRQ_STATUS: next_readdata = {29'h00000000, irq_status};
            asc_pkg::ADDR_IRQ_MASK: next_readdata = {29'h00000000, irq_mask};
            asc_pkg::ADDR_PHASE_ADV: next_readdata = {24'h000000, phase_advance};
            default: next_readdata = 32'h00000000;
        endcase
        if (!(avs_read && !ack))
            next_readdata = avs_readdata;
    end

    // ------------------------------------------------------------------
    // Register file next values
    // ------------------------------------------------------------------
    // Writes land at the edge where waitrequest is low.
    always_comb
    begin
        next_ack = (avs_read || avs_write) && !ack;
        next_cfg = cfg;
        next_mode = mode;
        next_sample_max = sample_max;
        next_vel_timer = vel_timer;
        next_drive_req = drive_req;
        next_irq_mask = irq_mask;
        if (wr_en)
        begin
            case (avs_address)
                asc_pkg::ADDR_CONFIG: next_cfg = avs_writedata[3:0];
                asc_pkg::ADDR_MODE: next_mode = avs_writedata[2:0];
                asc_pkg::ADDR_SAMPLE_MAX: next_sample_max = avs_writedata[15:0];
                asc_pkg::ADDR_VEL_TIMER:
                    next_vel_timer = (avs_writedata > 32'(asc_pkg::VEL_TIMER_MAX))
                        ? asc_pkg::VEL_TIMER_MAX : avs_writedata[7:0];
                asc_pkg::ADDR_DRIVE_REQ: next_drive_req = avs_writedata[15:0];
                asc_pkg::ADDR_IRQ_MASK: next_irq_mask = avs_writedata[asc_pkg::IRQ_W-1:0];
                default: next_cfg = cfg;
            endcase
        end
        // Halt latches set by pins and cleared only by the clear command.
        next_stop_hit = pin_s2[0] || (stop_hit && !clear_cmd);
        next_limit_hit = pin_s2[1] || (limit_hit && !clear_cmd);
        // Reading clears only the bits that were captured; new events win.
        next_irq_status = irq_status;
        if (rd_en && avs_address == asc_pkg::ADDR_IRQ_STATUS)
            next_irq_status = irq_status & ~avs_readdata[asc_pkg::IRQ_W-1:0];
        next_irq_status[asc_pkg::IRQ_STOP] = next_irq_status[asc_pkg::IRQ_STOP]
            | (pin_s2[0] && !stop_hit);
        next_irq_status[asc_pkg::IRQ_LIMIT] = next_irq_status[asc_pkg::IRQ_LIMIT]
            | (pin_s2[1] && !limit_hit);
        next_irq_status[asc_pkg::IRQ_TICK] = next_irq_status[asc_pkg::IRQ_TICK] | timer_tick;
    end

    // Drive command: clamp negatives in unipolar, else apply sign reversal.
    always_comb
    begin
        if (mode[asc_pkg::MODE_UNIPOLAR])
            next_motor_cmd = drive_req[15] ? 16'h0000 : drive_req;
        else if (cfg[asc_pkg::ST_SIGN_REV])
            next_motor_cmd = 16'(-drive_req);
        else
            next_motor_cmd = drive_req;
    end

    // Sync strobe sequencer: a request drives the shared line low.
    always_comb
    begin
        next_sync_state = sync_state;
        next_sync_cnt = sync_cnt;
        case (sync_state)
            SYNC_IDLE:
                if (sync_cmd)
                begin
                    next_sync_state = SYNC_STROBE;
                    next_sync_cnt = SYNC_LEN;
                end
            SYNC_STROBE:
                if (sync_cnt == 4'h1)
                    next_sync_state = SYNC_IDLE;
                else
                    next_sync_cnt = sync_cnt - 4'h1;
            default: next_sync_state = SYNC_IDLE;
        endcase
        next_sync_out_n = (next_sync_state != SYNC_STROBE);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Register every group of state except the pin synchronisers, which have their own block above.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack <= 1'b0;
            avs_readdata <= 32'h00000000;
            cfg <= asc_pkg::CONFIG_RST;
            mode <= asc_pkg::MODE_RST;
            sample_max <= asc_pkg::SAMPLE_MAX_RST;
            vel_timer <= asc_pkg::VEL_TIMER_RST;
            drive_req <= 16'h0000;
            motor_cmd <= 16'h0000;
            stop_hit <= 1'b0;
            limit_hit <= 1'b0;
            irq_status <= 3'h0;
            irq_mask <= asc_pkg::IRQ_MASK_RST;
            sync_state <= SYNC_IDLE;
            sync_cnt <= 4'h0;
            sync_out_n <= 1'b1;
            sync_prev <= 1'b1;
        end
        else
        begin
            ack <= next_ack;
            avs_readdata <= next_readdata;
            cfg <= next_cfg;
            mode <= next_mode;
            sample_max <= next_sample_max;
            vel_timer <= next_vel_timer;
            drive_req <= next_drive_req;
            motor_cmd <= next_motor_cmd;
            stop_hit <= next_stop_hit;
            limit_hit <= next_limit_hit;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            sync_state <= next_sync_state;
            sync_cnt <= next_sync_cnt;
            sync_out_n <= next_sync_out_n;
            sync_prev <= pin_s2[2];
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_sync_req;
        sync_cmd && sync_state == SYNC_IDLE;
    endsequence
    sequence s_strobe_low;
        !sync_out_n [*2] ##1 sync_out_n;
    endsequence
    property p_bit3_zero;
        @(posedge clk) disable iff (rst) state_word[3] == 1'b0 && !(ack && avs_read
            && avs_address == asc_pkg::ADDR_STATE && avs_readdata[3]);
    endproperty
    a_bit3_zero: assert property (p_bit3_zero) else $error("status bit 3 not zero");
    property p_cfg_reads;
        @(posedge clk) disable iff (rst) (wr_en && avs_address == asc_pkg::ADDR_CONFIG)
            |=> state_word[2:0] == $past(avs_writedata[2:0]);
    endproperty
    a_cfg_reads: assert property (p_cfg_reads) else $error("config not shown in status");
    property p_mode_bits;
        @(posedge clk) disable iff (rst) (wr_en && avs_address == asc_pkg::ADDR_MODE)
            |=> state_word[5:4] == $past(avs_writedata[1:0]);
    endproperty
    a_mode_bits: assert property (p_mode_bits) else $error("mode bits not shown");
    property p_stop_sticky;
        @(posedge clk) disable iff (rst)
        (!state_word[6] && !clear_cmd) |=> !state_word[6];
    endproperty
    a_stop_sticky: assert property (p_stop_sticky) else $error("stop bit self-cleared");
    property p_limit_sets;
        @(posedge clk) disable iff (rst) pin_s2[1] |=> !state_word[7];
    endproperty
    a_limit_sets: assert property (p_limit_sets) else $error("limit bit not set");
    property p_unipolar;
        @(posedge clk) disable iff (rst) mode[asc_pkg::MODE_UNIPOLAR] |=> !motor_cmd[15];
    endproperty
    a_unipolar: assert property (p_unipolar) else $error("negative unipolar drive");
    property p_vel_sat;
        @(posedge clk) disable iff (rst)
        (wr_en && avs_address == asc_pkg::ADDR_VEL_TIMER && avs_writedata > 32'h000000ff)
            |=> vel_timer == 8'hff;
    endproperty
    a_vel_sat: assert property (p_vel_sat) else $error("velocity timer not saturated");
    property p_sync_strobe;
        @(posedge clk) disable iff (rst) s_sync_req |=> s_strobe_low;
    endproperty
    a_sync_strobe: assert property (p_sync_strobe) else $error("sync strobe wrong");
    property p_realign_init;
        @(posedge clk) disable iff (rst) realign |=> timer_count == $past(sample_max);
    endproperty
    a_realign_init: assert property (p_realign_init) else $error("realign missed");
    property p_wait_bound;
        @(posedge clk) disable iff (rst) avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_bound: assert property (p_wait_bound) else $error("waitrequest too long");
endmodule // asc_axis

// >>> sim/asc_drive_model.sv
// Purpose: Far-side model: drive amplifier, encoder speed, halt switches, board sync line.
// Assumes: Switches and speed follow bench requests one clock later.
// Notes: The sync line has a pull-up; this axis is its only driver here.

`timescale 1ns/1ps

module asc_drive_model (
    // Clock
    input wire logic clk,
    // Bench requests
    input wire logic [7:0] speed_set,
    input wire logic stop_req,
    input wire logic limit_req,
    // Axis side
    input wire logic sync_out_n,
    input wire logic [15:0] motor_cmd,
    output logic [7:0] shaft_speed = 8'h00,
    output logic stop_in = 1'b0,
    output logic limit_in = 1'b0,
    output logic sync_in_n
);
    // Encoder speed and switches change just after a clock edge.
    always @(posedge clk)
    begin
        shaft_speed <= speed_set;
        stop_in <= stop_req;
        limit_in <= limit_req;
    end

    // Open-drain board sync line: low while an axis pulls it, else pulled up.
    assign sync_in_n = (sync_out_n === 1'b0) ? 1'b0 : 1'b1;
endmodule // asc_drive_model

// >>> sim/asc_axis_tb.sv
// Purpose: Self-checking bench for one axis.
// Assumes: One 20 MHz clock, synchronous reset held for three cycles.
// Notes: Status cases run from a table; halts, drive, velocity and sync follow by hand.

`timescale 1ns/1ps

`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end

module asc_axis_tb;
    // Stimulus and observed signals.
    logic clk, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, t0;
    logic stop_in, limit_in, sync_in_n, sync_out_n, stop_req = 1'b0, limit_req = 1'b0;
    logic [7:0] shaft_speed, speed_set = 8'h00, phase_advance;
    logic [15:0] motor_cmd;
    int miscompares = 0, tests_run = 0, cycles = 0, lows, gap;
    // One row: config, mode, expected status word.
    typedef struct {logic [3:0] cfg; logic [2:0] mode; logic [7:0] st;} asc_row_t;
    asc_row_t rows [5] = '{'{4'h0, 3'h0, 8'hc0}, '{4'h1, 3'h1, 8'hd1},
        '{4'h2, 3'h2, 8'he2}, '{4'h4, 3'h3, 8'hf4}, '{4'hf, 3'h4, 8'hc7}};

    asc_axis asc_axis_i (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .stop_in(stop_in),
        .limit_in(limit_in), .sync_in_n(sync_in_n), .sync_out_n(sync_out_n),
        .shaft_speed(shaft_speed), .motor_cmd(motor_cmd), .phase_advance(phase_advance));
    asc_drive_model asc_drive_model_i (.clk(clk), .speed_set(speed_set),
        .stop_req(stop_req), .limit_req(limit_req), .sync_out_n(sync_out_n),
        .motor_cmd(motor_cmd), .shaft_speed(shaft_speed), .stop_in(stop_in),
        .limit_in(limit_in), .sync_in_n(sync_in_n));

    // Clock of 50 ns period.
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("counts: %0d compared, %0d wrong", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Cuts a hang short.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            complete_run();
        end
    end

    // One bus access; held until waitrequest is sampled low, read data kept in rd.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Main sequence.
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK("sync_out_n", 1'b1, sync_out_n)
        bus(1'b0, asc_pkg::ADDR_STATE, 32'h0);
        `CHK("state reset", 8'he0, rd[7:0])
        bus(1'b0, asc_pkg::ADDR_SAMPLE_MAX, 32'h0);
        `CHK("sample max reset", 16'h00f9, rd[15:0])
        bus(1'b0, 4'hf, 32'h0);
        `CHK("unmapped read", 32'h0, rd)
        $display("test reset done");
        foreach (rows[i])
        begin
            bus(1'b1, asc_pkg::ADDR_CONFIG, {28'h0, rows[i].cfg});
            bus(1'b1, asc_pkg::ADDR_MODE, {29'h0, rows[i].mode});
            bus(1'b0, asc_pkg::ADDR_STATE, 32'h0);
            `CHK("state word", rows[i].st, rd[7:0])
        end
        $display("test status table done");
        // Both halts trigger with only they unmasked; status reads must not clear them.
        bus(1'b1, asc_pkg::ADDR_IRQ_MASK, 32'h3);
        stop_req <= 1'b1;
        limit_req <= 1'b1;
        repeat (2) @(posedge clk);
        stop_req <= 1'b0;
        limit_req <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK("irq raised", 1'b1, irq)
        repeat (2)
        begin
            bus(1'b0, asc_pkg::ADDR_STATE, 32'h0);
            `CHK("halted state", 8'h07, rd[7:0])
        end
        bus(1'b0, asc_pkg::ADDR_IRQ_STATUS, 32'h0);
        `CHK("irq status", 2'h3, rd[1:0])
        @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        bus(1'b1, asc_pkg::ADDR_COMMAND, 32'h2);
        bus(1'b0, asc_pkg::ADDR_STATE, 32'h0);
        `CHK("halt cleared", 8'hc7, rd[7:0])
        $display("test halts done");
        // Negative request in unipolar, bipolar and reversed bipolar mode.
        bus(1'b1, asc_pkg::ADDR_DRIVE_REQ, 32'hff00);
        repeat (3) @(posedge clk);
        `CHK("unipolar cmd", 16'h0000, motor_cmd)
        bus(1'b1, asc_pkg::ADDR_MODE, 32'h0);
        bus(1'b1, asc_pkg::ADDR_CONFIG, 32'h0);
        repeat (3) @(posedge clk);
        `CHK("bipolar cmd", 16'hff00, motor_cmd)
        bus(1'b1, asc_pkg::ADDR_CONFIG, 32'h1);
        repeat (3) @(posedge clk);
        `CHK("reversed cmd", 16'h0100, motor_cmd)
        $display("test drive done");
        // Velocity timer saturates; advance is speed times timer over 256.
        speed_set <= 8'hc8;
        bus(1'b1, asc_pkg::ADDR_VEL_TIMER, 32'h123);
        bus(1'b0, asc_pkg::ADDR_VEL_TIMER, 32'h0);
        `CHK("vel timer clamp", 8'hff, rd[7:0])
        bus(1'b1, asc_pkg::ADDR_VEL_TIMER, 32'h80);
        repeat (3) @(posedge clk);
        `CHK("phase advance pin", 8'h64, phase_advance)
        bus(1'b0, asc_pkg::ADDR_PHASE_ADV, 32'h0);
        `CHK("phase advance reg", 8'h64, rd[7:0])
        $display("test velocity done");
        // Same sample period as any other synced axis would be given.
        bus(1'b1, asc_pkg::ADDR_SAMPLE_MAX, 32'h0fff);
        repeat (300) @(posedge clk);
        bus(1'b0, asc_pkg::ADDR_SAMPLE_TIMER, 32'h0);
        t0 = rd;
        bus(1'b1, asc_pkg::ADDR_COMMAND, 32'h1);
        lows = 0;
        repeat (6)
        begin
            @(posedge clk);
            lows += (sync_out_n === 1'b0);
        end
        `CHK("sync low cycles", 2, lows)
        bus(1'b0, asc_pkg::ADDR_SAMPLE_TIMER, 32'h0);
        gap = t0[15:0] - rd[15:0];
        `CHK("timer not realigned", 1'b1, rd[15:0] < t0[15:0] && gap < 60)
        bus(1'b1, asc_pkg::ADDR_MODE, 32'h2);
        bus(1'b1, asc_pkg::ADDR_COMMAND, 32'h1);
        repeat (6) @(posedge clk);
        bus(1'b0, asc_pkg::ADDR_SAMPLE_TIMER, 32'h0);
        `CHK("timer realigned", 1'b1, rd[15:0] > 16'h0fff - 60)
        $display("test sync done");
        // A reset in mid-run brings status, drive and sync line back to idle.
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK("sync after reset", 1'b1, sync_out_n)
        `CHK("cmd after reset", 16'h0000, motor_cmd)
        `CHK("irq after reset", 1'b0, irq)
        bus(1'b0, asc_pkg::ADDR_STATE, 32'h0);
        `CHK("state after reset", 8'he0, rd[7:0])
        $display("test mid-run reset done");
        complete_run();
    end
endmodule // asc_axis_tb
